// file: lcc_top.sv
// lcc_top.sv - lockstep duplicate compare and buffer loopback check of one node
// assumes: master and checker copies share I_CLK; bus pins arrive asynchronously
//
// Summary of operation
// RULE_01 - toggle test signal through spare drivers
// RULE_02 - flag loopback error when return stops toggling
// RULE_03 - role latched at init, then held
// RULE_04 - copies run lockstep, compare every cycle
// RULE_05 - checker disables drivers, compares master outputs
// RULE_06 - checker samples address, data, control each cycle
// RULE_07 - any mismatch raises duplicate-compare error
// RULE_08 - only checker memory-bus drivers are disabled; code also disables the checker's peripheral-bus drivers
// RULE_09 - arbitration excluded from module compare
// RULE_10 - checker io node compares peripheral bus
// RULE_11 - io checker drives processor side normally
// RULE_12 - compare logic self-tested periodically; code self-tests the module comparator only
// RULE_13 - error starts report naming area, type, permanence
// RULE_14 - errors sticky until report accepted
`timescale 1ns/10ps
`include "lcc_consts.svh"
module lcc_top
   import lcc_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic I_INIT,
   input wire logic I_ROLE_CHECKER,
   input wire logic I_IO_NODE,
   input wire logic [`LCC_MBUS_W-1:0] I_MBUS_EXP,
   input wire logic [`LCC_MCTL_W-1:0] I_MCTL_EXP,
   input wire logic I_MBUS_EXP_VALID,
   input wire logic [`LCC_MBUS_W-1:0] I_MBUS_PIN,
   input wire logic [`LCC_MCTL_W-1:0] I_MCTL_PIN,
   input wire logic [`LCC_PBUS_W-1:0] I_PBUS_EXP,
   input wire logic I_PBUS_EXP_VALID,
   input wire logic [`LCC_PBUS_W-1:0] I_PBUS_PIN,
   input wire logic I_LOOP_RET,
   input wire logic I_RPT_ACK,
   output logic O_LOOP_DRV,
   output logic O_MBUS_OE_N,
   output logic O_PBUS_OE_N,
   output logic O_PROC_OE_N,
   output logic O_ROLE_CHECKER,
   output logic O_MOD_ERR,
   output logic O_LOOP_ERR,
   output logic O_PERIPH_ERR,
   output logic O_RPT_VALID,
   output logic [`LCC_ETYPE_W-1:0] O_RPT_TYPE,
   output logic O_RPT_PERM,
   output logic O_RPT_IO_AREA,
   output logic O_SELFTEST_FAIL
);
   // ==================================================
   // role selection
   lcc_role_t role_q; // current role, only changes at init
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         role_q <= LCC_MASTER;
      end else if (I_INIT) begin
         // role strap sampled only while initialising, then frozen
         role_q <= I_ROLE_CHECKER ? LCC_CHECKER : LCC_MASTER; // RULE_03
      end
   end
   wire logic is_chk = (role_q == LCC_CHECKER);
   logic io_q; // node kind, taken at init like the role
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         io_q <= 1'b0;
      end else if (I_INIT) begin
         io_q <= I_IO_NODE;
      end
   end

   // ==================================================
   // driver enables (active low)
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_MBUS_OE_N <= 1'b1; // all off until role known
         O_PBUS_OE_N <= 1'b1;
         O_PROC_OE_N <= 1'b1;
         O_ROLE_CHECKER <= 1'b0;
      end else begin
         O_MBUS_OE_N <= is_chk | I_INIT; // RULE_05 RULE_08
         O_PBUS_OE_N <= is_chk | ~io_q | I_INIT; // RULE_10
         // processor side stays driven in either role
         O_PROC_OE_N <= I_INIT; // RULE_11
         O_ROLE_CHECKER <= is_chk;
      end
   end

   // ==================================================
   // pin synchronisers: bus pins sampled every cycle
   logic [`LCC_MBUS_W-1:0] mbus_s1_q, mbus_s2_q;
   logic [`LCC_MCTL_W-1:0] mctl_s1_q, mctl_s2_q;
   logic [`LCC_PBUS_W-1:0] pbus_s1_q, pbus_s2_q;
   logic loop_s1_q, loop_s2_q;
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         mbus_s1_q <= '0;
         mbus_s2_q <= '0;
         mctl_s1_q <= '0;
         mctl_s2_q <= '0;
         pbus_s1_q <= '0;
         pbus_s2_q <= '0;
         loop_s1_q <= 1'b0;
         loop_s2_q <= 1'b0;
      end else begin
         mbus_s1_q <= I_MBUS_PIN; // RULE_06
         mbus_s2_q <= mbus_s1_q;
         mctl_s1_q <= I_MCTL_PIN; // RULE_06
         mctl_s2_q <= mctl_s1_q;
         pbus_s1_q <= I_PBUS_PIN;
         pbus_s2_q <= pbus_s1_q;
         loop_s1_q <= I_LOOP_RET;
         loop_s2_q <= loop_s1_q;
      end
   end

   // ==================================================
   // expected values delayed to line up with the synchronised pins
   // lockstep makes this a fixed two-cycle skew
   logic [`LCC_MBUS_W+`LCC_MCTL_W-1:0] mexp_d1_q, mexp_d2_q;
   logic [`LCC_PBUS_W-1:0] pexp_d1_q, pexp_d2_q;
   logic [1:0] mval_q, pval_q;
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         mexp_d1_q <= '0;
         mexp_d2_q <= '0;
         pexp_d1_q <= '0;
         pexp_d2_q <= '0;
         mval_q <= 2'h0;
         pval_q <= 2'h0;
      end else begin
         mexp_d1_q <= {I_MCTL_EXP, I_MBUS_EXP}; // RULE_04
         mexp_d2_q <= mexp_d1_q;
         pexp_d1_q <= I_PBUS_EXP;
         pexp_d2_q <= pexp_d1_q;
         mval_q <= {mval_q[0], I_MBUS_EXP_VALID};
         pval_q <= {pval_q[0], I_PBUS_EXP_VALID};
      end
   end

   // ==================================================
   // periodic self-test: inject one forced mismatch per period
   logic [`LCC_TEST_CNT_W-1:0] test_cnt_q;
   logic inject_q; // forced-miss cycle
   logic inject_d1_q; // aligns with comparator output
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         test_cnt_q <= '0;
         inject_q <= 1'b0;
         inject_d1_q <= 1'b0;
      end else begin
         test_cnt_q <= test_cnt_q + 1'b1;
         inject_q <= is_chk & ~I_INIT & (&test_cnt_q); // RULE_12
         inject_d1_q <= inject_q;
      end
   end

   // ==================================================
   // comparators; arbitration lines never enter the module compare
   logic mod_miss, per_miss;
   wire logic m_en = is_chk & ~I_INIT & mval_q[1];
   wire logic p_en = is_chk & io_q & ~I_INIT & pval_q[1];
   lcc_cmp #(.W(`LCC_MBUS_W + `LCC_MCTL_W)) u_mcmp (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .i_en(m_en | inject_q),
      .i_exp(mexp_d2_q),
      .i_obs({mctl_s2_q, mbus_s2_q}), // RULE_09
      .i_inject(inject_q),
      .o_mismatch(mod_miss) // RULE_07
   );
   lcc_cmp #(.W(`LCC_PBUS_W)) u_pcmp (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .i_en(p_en),
      .i_exp(pexp_d2_q),
      .i_obs(pbus_s2_q),
      .i_inject(1'b0),
      .o_mismatch(per_miss) // RULE_10
   );
   // a forced miss that fails to show means the comparator is broken
   wire logic mod_real = mod_miss & ~inject_d1_q;
   // enable as the comparator saw it, so the verdict judges the same cycle
   logic m_en_d1_q;
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         m_en_d1_q <= 1'b0;
      end else begin
         m_en_d1_q <= m_en;
      end
   end
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_SELFTEST_FAIL <= 1'b0;
      end else if (inject_d1_q & ~mod_miss & ~m_en_d1_q) begin
         O_SELFTEST_FAIL <= 1'b1; // RULE_12
      end
   end

   // ==================================================
   // loopback: toggle out, expect it back within the latency window
   logic [`LCC_LOOP_CNT_W-1:0] loop_cnt_q; // cycles since last change
   logic loop_prev_q;
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_LOOP_DRV <= 1'b0;
      end else begin
         // one spare driver per package, chained
         O_LOOP_DRV <= ~O_LOOP_DRV; // RULE_01
      end
   end
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         loop_prev_q <= 1'b0;
         loop_cnt_q <= '0;
      end else begin
         loop_prev_q <= loop_s2_q;
         if (I_INIT || (loop_s2_q != loop_prev_q)) begin
            // held clear while initialising so the chain and sync pipe can fill
            loop_cnt_q <= '0;
         end else if (loop_cnt_q != `LCC_LOOP_LAT) begin
            loop_cnt_q <= loop_cnt_q + 1'b1;
         end
      end
   end
   // a stuck return, once the pipe has filled, is a buffer fault
   wire logic loop_miss = ~I_INIT & (loop_cnt_q == `LCC_LOOP_LAT); // RULE_02

   // ==================================================
   // sticky error flags; set wins over the report acceptance
   logic ack_clr; // report accepted
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_MOD_ERR <= 1'b0;
         O_LOOP_ERR <= 1'b0;
         O_PERIPH_ERR <= 1'b0;
      end else begin
         O_MOD_ERR <= mod_real | (O_MOD_ERR & ~ack_clr); // RULE_14
         O_LOOP_ERR <= loop_miss | (O_LOOP_ERR & ~ack_clr); // RULE_14
         O_PERIPH_ERR <= per_miss | (O_PERIPH_ERR & ~ack_clr); // RULE_14
      end
   end

   // ==================================================
   // report: module error outranks the others
   lcc_rpt_t rpt_q;
   logic seen_q; // an error was already reported once: repeat means permanent
   assign ack_clr = (rpt_q == LCC_SEND) & I_RPT_ACK;
   wire logic any_err = O_MOD_ERR | O_LOOP_ERR | O_PERIPH_ERR;
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         rpt_q <= LCC_IDLE;
         O_RPT_VALID <= 1'b0;
         O_RPT_TYPE <= `LCC_ETYPE_NONE;
         O_RPT_PERM <= 1'b0;
         O_RPT_IO_AREA <= 1'b0;
         seen_q <= 1'b0;
      end else begin
         case (rpt_q)
            LCC_IDLE: begin
               if (any_err) begin
                  rpt_q <= LCC_SEND;
                  O_RPT_VALID <= 1'b1; // RULE_13
                  O_RPT_PERM <= seen_q;
                  O_RPT_IO_AREA <= ~O_MOD_ERR & ~O_LOOP_ERR;
                  if (O_MOD_ERR) begin
                     O_RPT_TYPE <= `LCC_ETYPE_MOD;
                  end else if (O_LOOP_ERR) begin
                     O_RPT_TYPE <= `LCC_ETYPE_LOOP;
                  end else begin
                     O_RPT_TYPE <= `LCC_ETYPE_PERIPH;
                  end
               end
            end
            LCC_SEND: begin
               if (I_RPT_ACK) begin
                  rpt_q <= LCC_WAIT;
                  O_RPT_VALID <= 1'b0;
                  seen_q <= 1'b1;
               end
            end
            default: begin
               // one quiet cycle so flags set during the ack start a fresh report
               rpt_q <= LCC_IDLE;
               O_RPT_TYPE <= `LCC_ETYPE_NONE;
            end
         endcase
      end
   end
endmodule

// file: lcc_consts.svh
// lcc_consts.svh - constants for the lockstep compare and loopback check block
// assumes: included by bare name from the package and the design modules
`ifndef LCC_CONSTS_SVH
`define LCC_CONSTS_SVH
// ==================================================
// widths of the compared interfaces
`define LCC_MBUS_W 32
`define LCC_MCTL_W 8
`define LCC_PBUS_W 16
// ==================================================
// loopback chain
`define LCC_LOOP_PKGS 3
// edges allowed for a toggle to come back through the chain and its synchroniser
`define LCC_LOOP_LAT 3'h4
`define LCC_LOOP_CNT_W 3
// ==================================================
// self-test period of the comparator, in clock cycles (2^n)
`define LCC_TEST_CNT_W 10
// ==================================================
// error type codes in the report
`define LCC_ETYPE_W 2
`define LCC_ETYPE_NONE 2'h0
`define LCC_ETYPE_MOD 2'h1
`define LCC_ETYPE_PERIPH 2'h2
`define LCC_ETYPE_LOOP 2'h3
`endif

// file: lcc_pkg.sv
// lcc_pkg.sv - types for the lockstep compare and loopback check block
// assumes: lcc_consts.svh sits in the same folder
`include "lcc_consts.svh"
package lcc_pkg;
   // role of this copy, fixed at initialization
   typedef enum logic {LCC_MASTER, LCC_CHECKER} lcc_role_t;
   // report hand-off states
   typedef enum logic [1:0] {LCC_IDLE, LCC_SEND, LCC_WAIT} lcc_rpt_t;
endpackage

// file: lcc_cmp.sv
// lcc_cmp.sv - registered bitwise comparator of expected against observed values
// assumes: both inputs are on the block clock; observed bits already synchronised
`timescale 1ns/10ps
module lcc_cmp #(
   parameter int W = 8
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_en,
   input wire logic [W-1:0] i_exp,
   input wire logic [W-1:0] i_obs,
   input wire logic i_inject,
   output logic o_mismatch
);
   // ==================================================
   // per-bit compare
   logic [W-1:0] diff; // one bit per differing line
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         assign diff[g] = i_exp[g] ^ i_obs[g];
      end
   endgenerate
   // ==================================================
   // registered result; inject flips the outcome so the path is exercised
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_mismatch <= 1'b0;
      end else begin
         o_mismatch <= i_en & ((|diff) ^ i_inject);
      end
   end
endmodule

// file: lcc_far_model.sv
// lcc_far_model.sv - spare-buffer loopback chain outside the node
// assumes: i_drv comes from the node; only the bench sets i_break
`timescale 1ns/10ps
module lcc_far_model (
   input wire logic i_clk,
   input wire logic i_drv,
   input wire logic i_break,
   output logic o_ret
);
   // ====================
   // chain of spare buffers
   // three packages in series, one spare driver each, modelled as one stage
   // of one cycle delay; a dead package freezes the whole chain
   logic ret_q; // level seen after the last spare driver
   // the return follows the drive unless a package failure is commanded
   always_ff @(posedge i_clk) begin
      if (!i_break) begin
         ret_q <= i_drv;
      end
   end
   assign o_ret = ret_q;
endmodule

// file: lcc_top_sva.sv
// lcc_top_sva.sv - port assertions for the lockstep compare block
// assumes: bound to lcc_top from the bench top file, one clock domain
`timescale 1ns/10ps
`include "lcc_consts.svh"
module lcc_top_sva (
   input wire logic I_CLK, I_RST, I_INIT, I_MBUS_EXP_VALID, I_LOOP_RET, I_RPT_ACK,
   input wire logic [`LCC_MBUS_W-1:0] I_MBUS_EXP, I_MBUS_PIN,
   input wire logic [`LCC_MCTL_W-1:0] I_MCTL_EXP, I_MCTL_PIN,
   input wire logic O_LOOP_DRV, O_MBUS_OE_N, O_PBUS_OE_N, O_PROC_OE_N, O_ROLE_CHECKER,
   input wire logic O_MOD_ERR, O_LOOP_ERR, O_RPT_VALID,
   input wire logic [`LCC_ETYPE_W-1:0] O_RPT_TYPE
);
   // ====================
   // clocking: reset aborts every attempt
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_RST);
   // checker-role compare that sees a real difference
   sequence s_miss;
      O_ROLE_CHECKER && !I_INIT && I_MBUS_EXP_VALID
         && ({I_MCTL_EXP, I_MBUS_EXP} != {I_MCTL_PIN, I_MBUS_PIN});
   endsequence
   // return frozen for eight cycles while no report is taken
   sequence s_stuck;
      (!I_INIT && !I_RPT_ACK && $stable(I_LOOP_RET)) [*8];
   endsequence
   // ====================
   // assertions
   a_loop_drv_toggle: assert property (!$past(I_RST) |-> O_LOOP_DRV != $past(O_LOOP_DRV))
      else $error("loop drive missed a toggle");
   a_loop_stuck_err: assert property (s_stuck |-> ##[0:4] O_LOOP_ERR)
      else $error("frozen return not flagged");
   a_role_held: assert property (!$past(I_INIT) |-> $stable(O_ROLE_CHECKER))
      else $error("role changed outside init");
   a_mbus_oe_off: assert property (O_ROLE_CHECKER |-> O_MBUS_OE_N)
      else $error("checker drives memory bus");
   a_pbus_oe_off: assert property (!O_PBUS_OE_N |-> !O_ROLE_CHECKER)
      else $error("checker drives peripheral bus");
   a_proc_oe_on: assert property (!$past(I_RST) && !$past(I_INIT) |-> !O_PROC_OE_N)
      else $error("processor side not driven");
   a_miss_flags: assert property (s_miss |-> ##[3:5] O_MOD_ERR)
      else $error("compare miss not flagged");
   a_err_reports: assert property ($rose(O_MOD_ERR) || $rose(O_LOOP_ERR) |-> ##[0:3] O_RPT_VALID)
      else $error("error without report");
   a_rpt_holds: assert property (O_RPT_VALID && !I_RPT_ACK |=> O_RPT_VALID && $stable(O_RPT_TYPE))
      else $error("report dropped before ack");
   a_ack_drops: assert property (O_RPT_VALID && I_RPT_ACK |=> ##[0:1] !O_RPT_VALID)
      else $error("report stays after ack");
endmodule

// file: tb_top.sv
// tb_top.sv - self-checking bench for the lockstep compare block
// assumes: lcc_pkg, lcc_far_model and lcc_top_sva compiled before
`timescale 1ns/10ps
`include "lcc_consts.svh"
module tb_top;
   // ====================
   // stimulus and observed signals
   logic clk = 1'b0, rst = 1'b1, init = 1'b1, role_chk = 1'b1, io_node = 1'b1;
   logic mval = 1'b1, pval = 1'b1, ack = 1'b0, brk = 1'b0, d;
   logic [`LCC_MBUS_W-1:0] mexp = '0, mpin = '0;
   logic [`LCC_MCTL_W-1:0] cexp = '0, cpin = '0;
   logic [`LCC_PBUS_W-1:0] pexp = '0, ppin = '0;
   logic loop_drv, loop_ret, mbus_oe_n, pbus_oe_n, proc_oe_n, role_q, st_fail;
   logic mod_err, loop_err, per_err, rpt_v, rpt_p, rpt_io;
   logic [`LCC_ETYPE_W-1:0] rpt_t;
   logic [39:0] f; // flip mask, control bits above bus bits
   int n_errors = 0;
   int total_checks = 0;
   lcc_top dut_u (
      .I_CLK(clk), .I_RST(rst), .I_INIT(init), .I_ROLE_CHECKER(role_chk), .I_IO_NODE(io_node),
      .I_MBUS_EXP(mexp), .I_MCTL_EXP(cexp), .I_MBUS_EXP_VALID(mval), .I_MBUS_PIN(mpin),
      .I_MCTL_PIN(cpin), .I_PBUS_EXP(pexp), .I_PBUS_EXP_VALID(pval), .I_PBUS_PIN(ppin),
      .I_LOOP_RET(loop_ret), .I_RPT_ACK(ack), .O_LOOP_DRV(loop_drv), .O_MBUS_OE_N(mbus_oe_n),
      .O_PBUS_OE_N(pbus_oe_n), .O_PROC_OE_N(proc_oe_n), .O_ROLE_CHECKER(role_q),
      .O_MOD_ERR(mod_err), .O_LOOP_ERR(loop_err), .O_PERIPH_ERR(per_err), .O_RPT_VALID(rpt_v),
      .O_RPT_TYPE(rpt_t), .O_RPT_PERM(rpt_p), .O_RPT_IO_AREA(rpt_io), .O_SELFTEST_FAIL(st_fail));
   lcc_far_model far_u (.i_clk(clk), .i_drv(loop_drv), .i_break(brk), .o_ret(loop_ret));
   always #10 clk = ~clk; // 50 MHz
   // ====================
   // helpers
   // one compare, counted; a miss is printed at once
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // lockstep traffic: pins copy the expected values, flipped where a miss is wanted
   task automatic cyc(input int n, input logic [39:0] mf, input logic [15:0] pf);
      logic [63:0] r;
      repeat (n) begin
         @(posedge clk);
         r = {$urandom, $urandom};
         {cexp, mexp} <= r[39:0];
         {cpin, mpin} <= r[39:0] ^ mf;
         pexp <= r[55:40];
         ppin <= r[55:40] ^ pf;
         #1;
      end
   endtask
   // wait for a report under a bound, check it, accept it; perm 2 means unchecked
   task automatic rpt(input logic [1:0] t, input int perm, input logic io);
      int k;
      k = 0;
      while (rpt_v !== 1'b1 && k < 20) begin
         cyc(1, '0, '0);
         k++;
      end
      if (rpt_v !== 1'b1) begin
         n_errors++;
         report_and_stop();
      end else begin
         chk(rpt_t, t);
         if (perm < 2) begin
            chk(rpt_p, perm);
         end
         chk(rpt_io, io);
         ack <= 1'b1;
         cyc(1, '0, '0);
         ack <= 1'b0;
         cyc(3, '0, '0);
         chk({rpt_v, mod_err, per_err, loop_err}, 4'h0);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ====================
   // main sequence
   initial begin
      void'($urandom(92083));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      cyc(3, '0, '0);
      init <= 1'b0;
      cyc(2, '0, '0);
      chk({role_q, mbus_oe_n, pbus_oe_n, proc_oe_n}, 4'he);
      d = loop_drv;
      cyc(1, '0, '0);
      chk(loop_drv, {31'h0, ~d});
      $display("test roles done");
      // long quiet run crosses a self-test slot of the comparator
      cyc(1100, '0, '0);
      chk({mod_err, per_err, loop_err, rpt_v, st_fail}, 5'h0);
      $display("test lockstep traffic done");
      // random bits, then the top bus bit and the top control bit
      for (int i = 0; i < 4; i++) begin
         f = 40'h1 << ((i < 2) ? $urandom_range(39) : 31 + 8 * (i - 2));
         cyc(1, f, '0);
         rpt(`LCC_ETYPE_MOD, i > 0, 1'b0);
      end
      cyc(1, '0, 16'h1 << $urandom_range(15));
      rpt(`LCC_ETYPE_PERIPH, 1, 1'b1);
      $display("test compare errors done");
      // no compare while the expected values are not valid
      mval <= 1'b0;
      pval <= 1'b0;
      cyc(1, '1, '1);
      cyc(8, '0, '0);
      chk({mod_err, per_err}, 2'h0);
      mval <= 1'b1;
      pval <= 1'b1;
      brk <= 1'b1;
      cyc(16, '0, '0);
      chk(loop_err, 1'b1);
      // the revived return needs the chain, two sync stages and the counter
      brk <= 1'b0;
      cyc(8, '0, '0);
      rpt(`LCC_ETYPE_LOOP, 2, 1'b0);
      $display("test loopback done");
      // master role drives every bus and never compares
      init <= 1'b1;
      role_chk <= 1'b0;
      cyc(2, '0, '0);
      init <= 1'b0;
      cyc(2, '0, '0);
      chk({role_q, mbus_oe_n, pbus_oe_n, proc_oe_n}, 4'h0);
      cyc(1, '1, '1);
      cyc(8, '0, '0);
      chk({mod_err, per_err, rpt_v}, 3'h0);
      // plain processor node: the peripheral bus is never driven
      init <= 1'b1;
      io_node <= 1'b0;
      cyc(2, '0, '0);
      init <= 1'b0;
      cyc(2, '0, '0);
      chk({mbus_oe_n, pbus_oe_n, proc_oe_n}, 3'h2);
      cyc(1, '0, '1);
      cyc(8, '0, '0);
      chk({per_err, rpt_v}, 2'h0);
      $display("test master role done");
      report_and_stop();
   end
endmodule
bind lcc_top lcc_top_sva chk_u (
   .I_CLK(I_CLK), .I_RST(I_RST), .I_INIT(I_INIT), .I_MBUS_EXP_VALID(I_MBUS_EXP_VALID),
   .I_LOOP_RET(I_LOOP_RET), .I_RPT_ACK(I_RPT_ACK), .I_MBUS_EXP(I_MBUS_EXP),
   .I_MBUS_PIN(I_MBUS_PIN), .I_MCTL_EXP(I_MCTL_EXP), .I_MCTL_PIN(I_MCTL_PIN),
   .O_LOOP_DRV(O_LOOP_DRV), .O_MBUS_OE_N(O_MBUS_OE_N), .O_PBUS_OE_N(O_PBUS_OE_N),
   .O_PROC_OE_N(O_PROC_OE_N), .O_ROLE_CHECKER(O_ROLE_CHECKER), .O_MOD_ERR(O_MOD_ERR),
   .O_LOOP_ERR(O_LOOP_ERR), .O_RPT_VALID(O_RPT_VALID), .O_RPT_TYPE(O_RPT_TYPE));
